// [logic/boot_flash_and_init_signal.sv]
`timescale 1ns/10ps
`include "boot_flash_defs.svh"

// Behaviour
// - Flash addressing uses 24 bits, reaching at most 16 megabytes.
// - Boot accesses run near 1.42 MHz, the code read at 25 MHz.
// - Boot only from select zero; second select stays inactive.
// - Copy program code from flash into program memory, then start init.
// - One single-bit serial link with standard flash commands.
// - Mode 0: clock idles low, data sampled on rising edge.
// - Status line undriven while reset is held.
// - Status line stays undriven until boot finishes.
// - After boot, drive status line high during auto-initialization.
// - Drive status line low when auto-initialization finishes.
// - Accept commands and video only after initialization completes.
// - Initialization completes about 2.94 s after reset release.
// - Write enable, poll status until latch set, then write status zero.
// - Fast read: opcode 0x0b, three address bytes, one dummy, data.
module boot_flash_and_init_signal
  import boot_flash_pkg::*;
#(
  parameter int PROG_BYTES = `PAGE_BYTES,
  parameter logic [`FLASH_ADDR_W-1:0] START_ADDR = 24'h000000,
  parameter int INIT_CYCLES = `INIT_CYCLES,
  parameter int PROG_AW = $clog2(PROG_BYTES)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial flash
  output flash_pins_t flashPins,
  input wire logic flashMiso,
  // Program memory read port
  input wire logic [PROG_AW-1:0] progRdAddr,
  output logic [7:0] progRdData,
  // Initialization status pin, tri-state style, output plus enable
  output logic initStatOut,
  output logic initStatOe,
  // Host acceptance
  output logic hostReady
);

  // ==========================================================
  // Declarations
  localparam logic [7:0] SLOW_HALF_C = 8'(`SLOW_HALF);
  localparam logic [7:0] FAST_HALF_C = 8'(`FAST_HALF);
  localparam logic [7:0] GAP_TICKS_C = 8'(`GAP_TICKS);
  localparam logic [15:0] HDR_C = 16'(`READ_HDR_BYTES);
  localparam logic [31:0] INIT_LAST_C = 32'(INIT_CYCLES - 1);

  boot_state_t state_q, nextState_q;
  logic [7:0] tickCnt_q, gapCnt_q, halfLim, loadByte;
  logic [7:0] txShift_q, rxShift_q;
  logic [7:0] progMem [PROG_BYTES];
  logic [2:0] bitCnt_q;
  logic [15:0] byteIdx_q;
  logic [31:0] initCnt_q;
  logic [PROG_AW-1:0] storeIdx;
  logic sclk_q, csN_q, fastMode_q;
  logic tick, byteDone, lastByte, startTxn, loadEn, storeEn, pollDone;

  // ==========================================================
  // Transaction decode
  function automatic logic [15:0] txn_len(boot_state_t s);
    case (s)
      ST_WRITE_ENABLE_CMD: txn_len = 16'd1;
      ST_POLL: txn_len = 16'd2;
      ST_WRSTAT: txn_len = 16'd2;
      ST_READ: txn_len = 16'(`READ_HDR_BYTES + PROG_BYTES);
      default: txn_len = 16'd1;
    endcase
  endfunction : txn_len

  function automatic logic [7:0] txn_byte(boot_state_t s, logic [15:0] idx);
    txn_byte = 8'h00;
    case (s)
      ST_WRITE_ENABLE_CMD: txn_byte = `OP_WRITE_ENABLE;
      ST_POLL: txn_byte = (idx == 16'd0) ? `OP_READ_STATUS : 8'h00;
      ST_WRSTAT: txn_byte = (idx == 16'd0) ? `OP_WRITE_STATUS : `STATUS_CLEAR;
      ST_READ: begin
        case (idx)
          16'd0: txn_byte = `OP_FAST_READ;
          16'd1: txn_byte = START_ADDR[23:16];
          16'd2: txn_byte = START_ADDR[15:8];
          16'd3: txn_byte = START_ADDR[7:0];
          default: txn_byte = 8'h00;
        endcase
      end
      default: txn_byte = 8'h00;
    endcase
  endfunction : txn_byte

  // ==========================================================
  // Bit rate enable
  assign halfLim = fastMode_q ? FAST_HALF_C : SLOW_HALF_C;
  assign tick = (tickCnt_q == halfLim - 8'd1);

  always_ff @(posedge mclk) begin
    if (sys_rst || tick) begin
      tickCnt_q <= 8'h00;
    end else begin
      tickCnt_q <= tickCnt_q + 8'd1;
    end
  end

  // Rate only rises once the boot writes are done
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fastMode_q <= 1'b0;
    end else if (startTxn && nextState_q == ST_READ) begin
      fastMode_q <= 1'b1;
    end
  end

  // ==========================================================
  // Byte engine
  assign byteDone = tick && !csN_q && sclk_q && (bitCnt_q == 3'd7);
  assign lastByte = (byteIdx_q == txn_len(state_q) - 16'd1);
  assign startTxn = (state_q == ST_GAP) && tick && (gapCnt_q == GAP_TICKS_C - 8'd1) && (nextState_q != ST_INIT);
  assign loadEn = startTxn || (byteDone && !lastByte);
  assign loadByte = startTxn ? txn_byte(nextState_q, 16'd0) : txn_byte(state_q, byteIdx_q + 16'd1);
  assign pollDone = byteDone && lastByte && (state_q == ST_POLL);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
      bitCnt_q <= 3'd0;
      txShift_q <= 8'h00;
      rxShift_q <= 8'h00;
    end else if (loadEn) begin
      txShift_q <= loadByte;
      bitCnt_q <= 3'd0;
      sclk_q <= 1'b0;
    end else if (tick && !csN_q) begin
      if (!sclk_q) begin
        sclk_q <= 1'b1;
        rxShift_q <= {rxShift_q[6:0], flashMiso};
      end else begin
        // Shift on the falling edge so data is settled before the next rise
        sclk_q <= 1'b0;
        bitCnt_q <= bitCnt_q + 3'd1;
        txShift_q <= {txShift_q[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Boot sequence
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_GAP;
      nextState_q <= ST_WRITE_ENABLE_CMD;
      csN_q <= 1'b1;
      byteIdx_q <= 16'd0;
      gapCnt_q <= 8'h00;
    end else begin
      case (state_q)
        ST_GAP: begin
          if (tick) begin
            if (gapCnt_q == GAP_TICKS_C - 8'd1) begin
              gapCnt_q <= 8'h00;
              state_q <= nextState_q;
              byteIdx_q <= 16'd0;
              csN_q <= (nextState_q == ST_INIT);
            end else begin
              gapCnt_q <= gapCnt_q + 8'd1;
            end
          end
        end
        ST_WRITE_ENABLE_CMD, ST_POLL, ST_WRSTAT, ST_READ: begin
          if (byteDone) begin
            if (lastByte) begin
              csN_q <= 1'b1;
              state_q <= ST_GAP;
              case (state_q)
                ST_WRITE_ENABLE_CMD: nextState_q <= ST_POLL;
                ST_POLL: nextState_q <= rxShift_q[`WRITE_LATCH_BIT] ? ST_WRSTAT : ST_POLL;
                ST_WRSTAT: nextState_q <= ST_READ;
                default: nextState_q <= ST_INIT;
              endcase
            end else begin
              byteIdx_q <= byteIdx_q + 16'd1;
            end
          end
        end
        ST_INIT: begin
          if (initCnt_q == INIT_LAST_C) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
        default: begin
          state_q <= ST_GAP;
        end
      endcase
    end
  end

  // Auto-initialization runs from program memory for a fixed span
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      initCnt_q <= 32'd0;
    end else if (state_q == ST_INIT) begin
      initCnt_q <= initCnt_q + 32'd1;
    end
  end

  // ==========================================================
  // Program memory
  assign storeEn = byteDone && (state_q == ST_READ) && (byteIdx_q >= HDR_C);
  assign storeIdx = PROG_AW'(byteIdx_q - HDR_C);

  always_ff @(posedge mclk) begin
    if (storeEn) begin
      progMem[storeIdx] <= rxShift_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      progRdData <= 8'h00;
    end else begin
      progRdData <= progMem[progRdAddr];
    end
  end

  // ==========================================================
  // Pins and status
  assign flashPins.sclk = sclk_q;
  assign flashPins.mosi = txShift_q[7];
  assign flashPins.selZeroN = csN_q;
  assign flashPins.selOneN = 1'b1;
  assign initStatOe = (state_q == ST_INIT) || (state_q == ST_DONE);
  assign initStatOut = (state_q == ST_INIT);
  assign hostReady = (state_q == ST_DONE);

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_second_select: assert property (flashPins.selOneN)
    else $error("second flash select became active");
  chk_clock_idle: assert property (flashPins.selZeroN |-> !flashPins.sclk)
    else $error("serial clock not low while deselected");
  chk_tick_spacing: assert property (tick |=> !tick [*3])
    else $error("bit rate enable faster than allowed");
  chk_rate_order: assert property ((state_q == ST_READ) |-> fastMode_q)
    else $error("code read not at fast rate");
  chk_slow_boot: assert property ((state_q inside {ST_WRITE_ENABLE_CMD, ST_POLL, ST_WRSTAT}) |-> !fastMode_q)
    else $error("boot writes not at slow rate");
  // Own disable: the default one would hide every reset cycle
  chk_reset_release: assert property (disable iff (1'b0) sys_rst |=> !initStatOe)
    else $error("status line driven after reset");
  chk_boot_undriven: assert property (!flashPins.selZeroN |-> !initStatOe)
    else $error("status line driven during boot");
  chk_init_high: assert property ($rose(initStatOe) |-> initStatOut && !hostReady && flashPins.selZeroN)
    else $error("status line not high during init");
  chk_done_low: assert property ($rose(hostReady) |-> $past(initStatOut) && !initStatOut && initStatOe)
    else $error("completion edge missing");
  chk_latch_wait: assert property ((pollDone && !rxShift_q[`WRITE_LATCH_BIT]) |=> nextState_q == ST_POLL)
    else $error("status written before latch set");
  chk_read_opcode: assert property (($fell(csN_q) && state_q == ST_READ) |-> txShift_q == `OP_FAST_READ)
    else $error("wrong read opcode");
  chk_addr_step: assert property ((byteDone && !lastByte && state_q == ST_READ)
    |=> byteIdx_q == $past(byteIdx_q) + 16'd1)
    else $error("read index did not advance by one");
  // Opcodes are looked at while their first bit is still on the wire
  chk_write_enable_cmd_opcode: assert property (($fell(csN_q) && state_q == ST_WRITE_ENABLE_CMD) |-> txShift_q == `OP_WRITE_ENABLE)
    else $error("wrong write enable opcode");
  chk_poll_opcode: assert property (($fell(csN_q) && state_q == ST_POLL) |-> txShift_q == `OP_READ_STATUS)
    else $error("wrong status read opcode");
  chk_wrstat_opcode: assert property (($fell(csN_q) && state_q == ST_WRSTAT)
    |-> txShift_q == `OP_WRITE_STATUS)
    else $error("wrong status write opcode");
  chk_poll_exit: assert property ((pollDone && rxShift_q[`WRITE_LATCH_BIT]) |=> nextState_q == ST_WRSTAT)
    else $error("latch set but status not written");
  chk_addr_high: assert property ((byteDone && state_q == ST_READ && byteIdx_q == 16'd0)
    |=> txShift_q == START_ADDR[23:16])
    else $error("wrong high address byte");
  chk_dummy_byte: assert property ((byteDone && state_q == ST_READ && byteIdx_q == 16'd3)
    |=> txShift_q == 8'h00)
    else $error("wrong dummy byte");
  chk_mosi_stable: assert property ((!csN_q && !$past(csN_q) && !$fell(sclk_q)) |-> $stable(txShift_q[7]))
    else $error("serial data moved outside a falling clock");
  chk_select_scope: assert property (!csN_q |-> state_q inside {ST_WRITE_ENABLE_CMD, ST_POLL, ST_WRSTAT, ST_READ})
    else $error("flash selected outside a transfer");
  chk_fast_half: assert property ((tick && fastMode_q) |=> !tick [*3] ##1 tick)
    else $error("fast bit rate not steady");
  chk_store_range: assert property (storeEn |-> byteIdx_q < 16'(`READ_HDR_BYTES + PROG_BYTES))
    else $error("store beyond program memory");
  chk_init_span: assert property ((state_q == ST_DONE) |-> initCnt_q == 32'(INIT_CYCLES))
    else $error("init span length wrong");
  chk_ready_hold: assert property (hostReady |=> hostReady && initStatOe && !initStatOut)
    else $error("completion levels not held");

  cov_poll_again: cover property (pollDone && !rxShift_q[`WRITE_LATCH_BIT]);
  cov_code_store: cover property (storeEn);
  cov_init_start: cover property ($rose(state_q == ST_INIT));
  cov_ready: cover property ($rose(hostReady));
  cov_fast_read: cover property ($fell(csN_q) && state_q == ST_READ);

endmodule : boot_flash_and_init_signal

// [shared/boot_flash_defs.svh]
`ifndef BOOT_FLASH_DEFS_SVH
`define BOOT_FLASH_DEFS_SVH

// ==========================================================
// Flash opcodes and status fields
`define OP_WRITE_ENABLE 8'h06
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_FAST_READ 8'h0b
`define STATUS_CLEAR 8'h00
`define WRITE_LATCH_BIT 1
`define READ_HDR_BYTES 5
`define FLASH_ADDR_W 24
`define FLASH_MAX_BYTES 16777216
`define PAGE_BYTES 256

// ==========================================================
// Timing
`define CLK_HZ 200000000
`define SLOW_HZ 1420000
`define FAST_HZ 30000000
// Half periods round up so the flash never sees more than nominal rate
`define SLOW_HALF ((`CLK_HZ + 2 * `SLOW_HZ - 1) / (2 * `SLOW_HZ))
`define FAST_HALF ((`CLK_HZ + 2 * `FAST_HZ - 1) / (2 * `FAST_HZ))
`define GAP_TICKS 2
`define INIT_TIME_MS 2940
`define INIT_CYCLES (`INIT_TIME_MS * (`CLK_HZ / 1000))

`endif

// [shared/boot_flash_pkg.sv]
package boot_flash_pkg;

  typedef enum logic [2:0] {
    ST_GAP,
    ST_WRITE_ENABLE_CMD,
    ST_POLL,
    ST_WRSTAT,
    ST_READ,
    ST_INIT,
    ST_DONE
  } boot_state_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic selZeroN;
    logic selOneN;
  } flash_pins_t;

endpackage : boot_flash_pkg

// [sim/boot_flash_and_init_signal_tb.sv]
`timescale 1ns/10ps
`include "boot_flash_defs.svh"

module boot_flash_and_init_signal_tb;
  import boot_flash_pkg::*;
  localparam int NB = 8;
  localparam int INITC = 50;
  // Each status poll sends its opcode and one byte while the status comes back
  localparam int NBYTES = 12 + NB;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic flashMiso;
  logic [2:0] progRdAddr = 3'h0;
  logic [7:0] progRdData;
  logic initStatOut;
  logic initStatOe;
  logic hostReady;
  logic statWire;
  logic selPrev = 1'b1;
  logic sclkPrev = 1'b0;
  logic [7:0] sh = 8'h00;
  flash_pins_t pins;
  logic [7:0] bq [$];
  logic [7:0] exp [12];
  int err_total = 0;
  int checks = 0;
  int rstCyc = 0;
  int tidx = -1;
  int halfCnt = 0;
  int bits = 0;
  int n;
  int k;

  always #2.5 mclk = ~mclk;
  // Board pull-up on the status line
  assign statWire = initStatOe ? initStatOut : 1'b1;

  boot_flash_and_init_signal #(.PROG_BYTES(NB), .INIT_CYCLES(INITC)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .flashPins(pins), .flashMiso(flashMiso), .progRdAddr(progRdAddr),
    .progRdData(progRdData), .initStatOut(initStatOut), .initStatOe(initStatOe), .hostReady(hostReady)
  );

  spi_flash_model fm (.sclk(pins.sclk), .mosi(pins.mosi), .selN(pins.selZeroN), .miso(flashMiso));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic give_verdict;
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Wire monitor: framing, clock rate, byte capture
  always @(posedge mclk) begin
    if (sys_rst) begin
      // First edge still shows the state from before reset
      if (rstCyc > 0) chk("stat_oe_reset", 1'b0, initStatOe);
      rstCyc++;
    end else begin
      chk("second_select", 1'b1, pins.selOneN);
      if (pins.selZeroN === 1'b1) chk("sclk_idle", 1'b0, pins.sclk);
      if (bq.size() < NBYTES) chk("stat_wire_boot", 1'b1, statWire);
      if (bq.size() < NBYTES) chk("stat_oe_boot", 1'b0, initStatOe);
      if (pins.selZeroN === 1'b0 && selPrev === 1'b1) begin
        tidx++;
        halfCnt = 1;
        bits = 0;
      end else if (selPrev === 1'b0 && pins.sclk !== sclkPrev) begin
        chk("half_period", (tidx < 4) ? `SLOW_HALF : `FAST_HALF, halfCnt);
        halfCnt = 1;
        if (pins.sclk === 1'b1) begin
          sh = {sh[6:0], pins.mosi};
          bits++;
          if (bits % 8 == 0) bq.push_back(sh);
        end
      end else begin
        halfCnt++;
      end
      selPrev = pins.selZeroN;
      sclkPrev = pins.sclk;
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'he776));
    for (int i = 0; i < 256; i++) fm.mem[i] = 8'($urandom);
    exp = '{8'h06, 8'h05, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h0b, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    n = 0;
    while (initStatOe !== 1'b1 && n < 40000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("stat_high", 1'b1, initStatOut);
    chk("ready_early", 1'b0, hostReady);
    n = 0;
    while (initStatOut === 1'b1 && n < 1000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("init_len", INITC, n);
    chk("stat_low", 1'b0, statWire);
    chk("stat_oe_done", 1'b1, initStatOe);
    chk("host_ready", 1'b1, hostReady);
    chk("byte_count", NBYTES, bq.size());
    foreach (exp[i]) chk("cmd_byte", exp[i], bq[i]);
    chk("transactions", 4, tidx);
    chk("flash_status", 8'h00, fm.stat);
    for (int i = 0; i < 2 * NB; i++) begin
      k = (i < NB) ? i : $urandom_range(NB - 1);
      @(posedge mclk);
      progRdAddr <= k[2:0];
      @(posedge mclk);
      #1;
      chk("prog_byte", fm.mem[k], progRdData);
    end
    give_verdict;
  end

  // Boot takes about 9600 cycles; allow over six times that
  initial begin
    #300000;
    err_total++;
    give_verdict;
  end
endmodule : boot_flash_and_init_signal_tb

// [sim/spi_flash_model.sv]
`timescale 1ns/10ps

module spi_flash_model (
  // Serial link
  input wire logic sclk,
  input wire logic mosi,
  input wire logic selN,
  output logic miso
);
  // ==========================================================
  // Storage and status
  logic [7:0] mem [0:255];
  logic [7:0] sh = 8'h00;
  logic [7:0] cmd = 8'h00;
  logic [7:0] outb = 8'h00;
  // Protection bits start set, as a cautious part would ship
  logic [7:0] stat = 8'h9c;
  logic [23:0] addr = 24'h000000;
  logic write_latch_flag = 1'b0;
  logic arm = 1'b0;
  int bits = 0;
  int nbyte = 0;

  initial miso = 1'b0;

  // ==========================================================
  // Command decode, sampled on rising clock
  always @(negedge selN) begin
    bits = 0;
    nbyte = 0;
  end

  always @(posedge sclk) begin
    if (!selN) begin
      sh = {sh[6:0], mosi};
      bits++;
      if (bits % 8 == 0) begin
        if (nbyte == 0) cmd = sh;
        // Latch shows only on the second poll, so polling must repeat
        if (nbyte == 0 && sh == 8'h06) arm = 1'b1;
        if (nbyte == 0 && sh == 8'h05) begin
          outb = {stat[7:2], write_latch_flag, 1'b0};
          if (arm) write_latch_flag = 1'b1;
        end
        if (nbyte == 1 && cmd == 8'h01 && write_latch_flag) begin
          stat = sh;
          write_latch_flag = 1'b0;
          arm = 1'b0;
        end
        if (cmd == 8'h0b && nbyte >= 1 && nbyte <= 3) addr = {addr[15:0], sh};
        if (cmd == 8'h0b && nbyte >= 4) begin
          outb = mem[addr[7:0]];
          addr = addr + 24'h000001;
        end
        nbyte++;
      end
    end
  end

  // ==========================================================
  // Output on falling clock; released line shows garbage
  always @(negedge sclk) begin
    if (!selN) miso <= outb[7 - (bits % 8)];
  end

  always @(posedge selN) miso <= ~miso;
endmodule : spi_flash_model
